// [interval_timer.sv]
// One-shot cycle timer: busy for a loaded number of cycles, then a done pulse.
// Assumes start is a one-cycle pulse; a start while busy reloads.
`timescale 1ns/1ps
module interval_timer #(
	parameter int W = pm_regs_pkg::TIMER_W
) (
	input  wire logic         sys_clk_in,  // System clock
	input  wire logic         rst_n_in,    // Async reset, active low
	input  wire logic         start_in,    // Start pulse
	input  wire logic [W-1:0] cycles_in,   // Length in cycles, 0 means none
	output logic              busy_out,    // High while counting
	output logic              done_out     // One-cycle pulse at the end
);
	if (W < 2)
	begin : g_width_check
		$error("interval_timer: W too small");
	end

	typedef struct packed {
		logic [W-1:0] count;
		logic         busy;
		logic         done;
	} st_s;

	st_s st_reg;
	st_s st_next;

	always_comb
	begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		if (start_in)
		begin
			if (cycles_in == '0)
			begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
			else
			begin
				st_next.count = cycles_in;
				st_next.busy  = 1'b1;
			end
		end
		else if (st_reg.busy)
		begin
			st_next.count = st_reg.count - W'(1);
			if (st_reg.count == W'(1))
			begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign busy_out = st_reg.busy;
	assign done_out = st_reg.done;

endmodule : interval_timer

// [irq_mask_and_shutdown_timing.sv]
// Fault mask, switch gap and fast-shutdown timing registers behind a serial port.
// Assumes serial pins synchronous to sys_clk_in and sclk well below clock/2.
//
// Behaviour
// - Mask bit 6 blocks illumination-fault interrupt when one, passes when zero.
// - Mask bit 5 blocks projector-on change interrupt when one.
// - Mask bit 4 blocks mirror-array fault interrupt when one.
// - Mask bit 3 blocks low-supply shutdown interrupt when one.
// - Mask bit 2 blocks low-supply warning interrupt when one.
// - Mask bit 1 blocks thermal shutdown interrupt when one.
// - Mask bit 0 blocks thermal warning interrupt when one.
// - Mask bit 7 blocks low-voltage supply fault interrupt when one.
// - Gap code zero gives no gap; code n gives 222 plus 111n ns.
// - Shutdown bits 7:4 time offset/reset step, bits 3:0 bias/reset step.
`timescale 1ns/1ps
module irq_mask_and_shutdown_timing #(
	parameter int unsigned CLK_PERIOD_NS = pm_regs_pkg::CLK_PERIOD_NS
) (
	input  wire logic       sys_clk_in,                // System clock, 10 MHz
	input  wire logic       rst_n_in,                  // Async reset, active low
	input  wire logic       sclk_in,                   // Serial clock
	input  wire logic       cs_n_in,                   // Serial select, active low
	input  wire logic       mosi_in,                   // Serial data in
	output logic            miso_out,                  // Serial data out
	output logic            miso_oe_out,               // Drive enable for miso
	input  wire logic [7:0] fault_src_in,              // Fault and warning levels
	output logic            irq_n_out,                 // Interrupt, active low
	input  wire logic       led_switch_req_in,         // LED switch request pulse
	output logic            switch_gap_active_out,     // High during switch gap
	output logic            switch_go_out,             // Pulse when gap ends
	input  wire logic       fast_shutdown_in,          // Fast shutdown start pulse
	output logic            offset_reset_step_out,     // Pulse: offset/reset step
	output logic            bias_reset_rail_step_out,  // Pulse: bias/reset rail step
	output logic            shutdown_busy_out          // High during shutdown
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (CLK_PERIOD_NS < 63)
	begin : g_period_check
		$error("CLK_PERIOD_NS too small for timer width");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		pm_regs_pkg::spi_pins_s  pins;
		logic [4:0]              bit_cnt;
		logic [7:0]              cmd;
		logic [7:0]              shift_in;
		logic [7:0]              shift_out;
		logic                    miso;
		logic [7:0]              src_prev;
		logic [7:0]              status;
		logic [7:0]              mask;
		logic [7:0]              gap;
		logic [7:0]              fsd;
		logic [7:0]              ofs_dur;
		pm_regs_pkg::fsd_state_e fsd_state;
		logic [pm_regs_pkg::TIMER_W:0] bias_wait;
	} st_s;

	st_s st_reg;
	st_s st_next;

	localparam st_s ST_RESET = '{
		pins:      '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0},
		bit_cnt:   5'h00,
		cmd:       8'h00,
		shift_in:  8'h00,
		shift_out: 8'h00,
		miso:      1'b0,
		src_prev:  8'h00,
		status:    pm_regs_pkg::STATUS_RESET,
		mask:      pm_regs_pkg::MASK_RESET,
		gap:       pm_regs_pkg::GAP_RESET,
		fsd:       pm_regs_pkg::FSD_RESET,
		ofs_dur:   pm_regs_pkg::OFS_DUR_RESET,
		fsd_state: pm_regs_pkg::FSD_IDLE,
		bias_wait: '0
	};

	logic                                   sclk_rise;
	logic                                   sclk_fall;
	logic [7:0]                             src_rise;
	logic [7:0]                             clear_bits;
	logic [7:0]                             rd_data;
	logic [7:0]                             byte_in;
	logic [pm_regs_pkg::TIMER_W-1:0]        gap_cycles;
	logic [pm_regs_pkg::TIMER_W-1:0]        fsd_cycles;
	logic [3:0]                             fsd_code;
	logic                                   fsd_start;
	logic                                   fsd_done;
	logic                                   fsd_busy;
	logic                                   gap_done;

	assign sclk_rise = !st_reg.pins.sclk && sclk_in && !cs_n_in;
	assign sclk_fall = st_reg.pins.sclk && !sclk_in && !cs_n_in;
	assign byte_in   = {st_reg.shift_in[6:0], mosi_in};

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb
	begin
		case (byte_in[6:0])
			pm_regs_pkg::STATUS_ADDR:  rd_data = st_reg.status;
			pm_regs_pkg::MASK_ADDR:    rd_data = st_reg.mask;
			pm_regs_pkg::GAP_ADDR:     rd_data = st_reg.gap;
			pm_regs_pkg::FSD_ADDR:     rd_data = st_reg.fsd;
			pm_regs_pkg::OFS_DUR_ADDR: rd_data = st_reg.ofs_dur;
			default:                   rd_data = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Delay lookup
	// ----------------------------------------
	// Gap is 222 + 111n ns, rounded up to whole cycles
	assign gap_cycles = (st_reg.gap == 8'h00) ? '0 :
		pm_regs_pkg::ns_to_cycles(pm_regs_pkg::GAP_BASE_NS + pm_regs_pkg::GAP_STEP_NS * st_reg.gap,
			CLK_PERIOD_NS);
	// Same table serves both shutdown steps; lower window edge is used
	// Idle start takes the offset code, the start at the offset step the bias code
	assign fsd_code   = (st_reg.fsd_state == pm_regs_pkg::FSD_IDLE)
		? st_reg.fsd[pm_regs_pkg::FSD_OFS_LSB +: 4] : st_reg.fsd[pm_regs_pkg::FSD_BIAS_LSB +: 4];
	assign fsd_cycles = pm_regs_pkg::ns_to_cycles(pm_regs_pkg::FSD_MIN_NS[fsd_code], CLK_PERIOD_NS);
	assign fsd_start  = (fast_shutdown_in && st_reg.fsd_state == pm_regs_pkg::FSD_IDLE)
		|| (fsd_done && st_reg.fsd_state == pm_regs_pkg::FSD_OFS);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_next          = st_reg;
		st_next.pins     = '{sclk: sclk_in, cs_n: cs_n_in, mosi: mosi_in};
		st_next.src_prev = fault_src_in;
		src_rise         = fault_src_in & ~st_reg.src_prev;
		clear_bits       = 8'h00;

		if (cs_n_in)
		begin
			st_next.bit_cnt = 5'h00;
		end
		else if (sclk_rise)
		begin
			st_next.shift_in = byte_in;
			st_next.bit_cnt  = st_reg.bit_cnt + 5'h01;
			if (st_reg.bit_cnt == 5'h07)
			begin
				st_next.cmd       = byte_in;
				st_next.shift_out = rd_data;
			end
			else if (st_reg.bit_cnt == 5'(pm_regs_pkg::SPI_BITS - 1) && st_reg.cmd[pm_regs_pkg::SPI_WRITE_BIT])
			begin
				case (st_reg.cmd[6:0])
					pm_regs_pkg::STATUS_ADDR:  clear_bits      = byte_in;
					pm_regs_pkg::MASK_ADDR:    st_next.mask    = byte_in;
					pm_regs_pkg::GAP_ADDR:     st_next.gap     = byte_in;
					pm_regs_pkg::FSD_ADDR:     st_next.fsd     = byte_in;
					pm_regs_pkg::OFS_DUR_ADDR: st_next.ofs_dur = byte_in;
					default:                   clear_bits      = 8'h00;
				endcase
			end
		end
		else if (sclk_fall && st_reg.bit_cnt >= 5'h08)
		begin
			st_next.miso      = st_reg.shift_out[7];
			st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
		end

		// Set beats a same-cycle write-one clear; mask plays no part here
		st_next.status = (st_reg.status & ~clear_bits) | src_rise;

		case (st_reg.fsd_state)
			pm_regs_pkg::FSD_IDLE:
				if (fast_shutdown_in)
					st_next.fsd_state = pm_regs_pkg::FSD_OFS;
			pm_regs_pkg::FSD_OFS:
				if (fsd_done)
					st_next.fsd_state = pm_regs_pkg::FSD_BIAS;
			pm_regs_pkg::FSD_BIAS:
				if (fsd_done)
					st_next.fsd_state = pm_regs_pkg::FSD_IDLE;
			default:
				st_next.fsd_state = pm_regs_pkg::FSD_IDLE;
		endcase

		// Cycles spent waiting for the bias step; only the bound check reads it
		st_next.bias_wait = (st_reg.fsd_state == pm_regs_pkg::FSD_BIAS)
			? st_reg.bias_wait + (pm_regs_pkg::TIMER_W+1)'(1) : '0;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_reg <= ST_RESET;
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	interval_timer #(.W(pm_regs_pkg::TIMER_W)) gap_timer (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (led_switch_req_in),
		.cycles_in  (gap_cycles),
		.busy_out   (switch_gap_active_out),
		.done_out   (gap_done)
	);

	interval_timer #(.W(pm_regs_pkg::TIMER_W)) fsd_timer (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (fsd_start),
		.cycles_in  (fsd_cycles),
		.busy_out   (fsd_busy),
		.done_out   (fsd_done)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Unmasked sticky status drives the shared interrupt line
	assign irq_n_out                = ~|(st_reg.status & ~st_reg.mask);
	assign miso_out                 = st_reg.miso;
	assign miso_oe_out              = !st_reg.pins.cs_n && !cs_n_in;
	assign switch_go_out            = gap_done;
	assign offset_reset_step_out    = fsd_done && st_reg.fsd_state == pm_regs_pkg::FSD_OFS;
	assign bias_reset_rail_step_out = fsd_done && st_reg.fsd_state == pm_regs_pkg::FSD_BIAS;
	assign shutdown_busy_out        = st_reg.fsd_state != pm_regs_pkg::FSD_IDLE || fsd_busy;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_mask6;
		st_reg.status[6] && !st_reg.mask[6] |-> !irq_n_out;
	endproperty
	a_mask6: assert property (p_mask6) else $error("illumination fault not signalled");

	property p_mask5;
		(st_reg.status & ~st_reg.mask) == 8'h20 |-> !irq_n_out && !st_reg.mask[5];
	endproperty
	a_mask5: assert property (p_mask5) else $error("projector-on change not signalled");

	property p_mask4;
		st_reg.status == 8'h10 && st_reg.mask[4] |-> irq_n_out;
	endproperty
	a_mask4: assert property (p_mask4) else $error("masked mirror fault leaked");

	property p_mask3;
		st_reg.status[3] && !st_reg.mask[3] |-> !irq_n_out;
	endproperty
	a_mask3: assert property (p_mask3) else $error("low-supply shutdown not signalled");

	property p_mask2;
		st_reg.status == 8'h04 && st_reg.mask[2] |-> irq_n_out;
	endproperty
	a_mask2: assert property (p_mask2) else $error("masked low-supply warning leaked");

	property p_mask1;
		st_reg.status[1] && !st_reg.mask[1] |-> !irq_n_out;
	endproperty
	a_mask1: assert property (p_mask1) else $error("thermal shutdown not signalled");

	property p_mask0;
		st_reg.status == 8'h01 && st_reg.mask[0] |-> irq_n_out;
	endproperty
	a_mask0: assert property (p_mask0) else $error("masked thermal warning leaked");

	property p_mask7;
		st_reg.status == 8'h80 |-> irq_n_out == st_reg.mask[7];
	endproperty
	a_mask7: assert property (p_mask7) else $error("supply fault mask wrong");

	sequence s_gap_start;
		led_switch_req_in && st_reg.gap == 8'h01 && !switch_gap_active_out;
	endsequence
	property p_gap;
		s_gap_start |=> switch_gap_active_out [*4] ##1 !switch_gap_active_out && switch_go_out;
	endproperty
	a_gap: assert property (p_gap) else $error("gap for code 1 not four cycles");

	property p_gap_zero;
		led_switch_req_in && st_reg.gap == 8'h00 |=> switch_go_out && !switch_gap_active_out;
	endproperty
	a_gap_zero: assert property (p_gap_zero) else $error("zero gap code delayed");

	sequence s_fsd_start;
		fast_shutdown_in && st_reg.fsd_state == pm_regs_pkg::FSD_IDLE && st_reg.fsd[7:4] == 4'h0;
	endsequence
	// Code 0 waits 40 cycles, so the single offset pulse shows 41 cycles after start
	property p_fsd_ofs;
		s_fsd_start |-> ##41 offset_reset_step_out;
	endproperty
	a_fsd_ofs: assert property (p_fsd_ofs) else $error("offset step not 41 cycles after start");

	property p_fsd_order;
		offset_reset_step_out |=> st_reg.fsd_state == pm_regs_pkg::FSD_BIAS && fsd_busy;
	endproperty
	a_fsd_order: assert property (p_fsd_order) else $error("bias step not started after offset step");

	// Longest table entry bounds the wait for the bias step
	localparam logic [pm_regs_pkg::TIMER_W:0] BIAS_WAIT_MAX = (pm_regs_pkg::TIMER_W+1)'(
		(pm_regs_pkg::FSD_MIN_NS[15] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	property p_fsd_bias_bound;
		st_reg.fsd_state == pm_regs_pkg::FSD_BIAS |-> st_reg.bias_wait <= BIAS_WAIT_MAX;
	endproperty
	a_fsd_bias_bound: assert property (p_fsd_bias_bound) else $error("bias step overdue");

	property p_status_set;
		fault_src_in[4] && !st_reg.src_prev[4] && st_reg.mask[4] |=> st_reg.status[4];
	endproperty
	a_status_set: assert property (p_status_set) else $error("masked source lost status");

endmodule : irq_mask_and_shutdown_timing

// [pm_regs_pkg.sv]
// Shared constants and types for the fault-mask and shutdown timing bank.
// Assumes a single 10 MHz system clock and a serial register port.
package pm_regs_pkg;

	// ----------------------------------------
	// Register addresses and reset values
	// ----------------------------------------
	localparam logic [6:0] STATUS_ADDR   = 7'h0c;
	localparam logic [6:0] MASK_ADDR     = 7'h0d;
	localparam logic [6:0] GAP_ADDR      = 7'h0e;
	localparam logic [6:0] FSD_ADDR      = 7'h0f;
	localparam logic [6:0] OFS_DUR_ADDR  = 7'h10;

	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [7:0] MASK_RESET    = 8'hf5;
	localparam logic [7:0] GAP_RESET     = 8'h00;
	localparam logic [7:0] FSD_RESET     = 8'h07;
	localparam logic [7:0] OFS_DUR_RESET = 8'hc0;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SUPPLY_FAULT_BIT   = 7;
	localparam int ILLUMINATION_FAULT_BIT = 6;
	localparam int PROJ_ON_BIT        = 5;
	localparam int MIRROR_FAULT_BIT   = 4;
	localparam int LOW_SHUT_BIT       = 3;
	localparam int LOW_WARN_BIT       = 2;
	localparam int THERM_SHUT_BIT     = 1;
	localparam int THERM_WARN_BIT     = 0;
	localparam int FSD_OFS_LSB        = 4;
	localparam int FSD_BIAS_LSB       = 0;
	localparam int SPI_WRITE_BIT      = 7;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned GAP_BASE_NS   = 222;
	localparam int unsigned GAP_STEP_NS   = 111;
	localparam int          TIMER_W       = 14;
	localparam int          SPI_BITS      = 16;

	// Lower edge of each shutdown delay window, in ns
	localparam int unsigned FSD_MIN_NS [16] = '{
		4000, 8010, 16020, 32000, 63990, 128000, 256000, 512100,
		6230, 12460, 24890, 49770, 99500, 199100, 398300, 1024200};

	typedef enum logic [1:0] {
		FSD_IDLE = 2'b00,
		FSD_OFS  = 2'b01,
		FSD_BIAS = 2'b10
	} fsd_state_e;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
	} spi_pins_s;

	typedef struct packed {
		logic [TIMER_W-1:0] count;
		logic               busy;
		logic               done;
	} timer_state_s;

	// Least time rounds up, never below one cycle
	function automatic logic [TIMER_W-1:0] ns_to_cycles(input int unsigned ns, input int unsigned period);
		int unsigned c;
		c = (ns + period - 1) / period;
		if (c < 1)
			c = 1;
		return TIMER_W'(c);
	endfunction : ns_to_cycles

endpackage : pm_regs_pkg

// [spi_host_model.sv]
// Host side of the serial register port: sends 16-bit frames, captures read data.
// Assumes mode 0 framing, MSB first, with every level held for several device clocks.
`timescale 1ns/1ps
module spi_host_model #(
	parameter int HALF_CYCLES = 4
) (
	input  wire logic             sys_clk_in,  // Device clock
	input  wire logic             miso_in,     // Read data from device
	input  wire logic             miso_oe_in,  // Device drives read data
	output pm_regs_pkg::spi_pins_s pins_out    // Serial clock, select, data
);
	initial pins_out = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask : wait_cycles

	// ----------------------------------------
	// One whole frame
	// ----------------------------------------
	task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge sys_clk_in);
		pins_out.cs_n <= 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			pins_out.mosi <= frame[15-i];
			wait_cycles(HALF_CYCLES);
			// Undriven line must not pass for data
			if (i >= 8)
				rd[15-i] = miso_oe_in ? miso_in : 1'bx;
			pins_out.sclk <= 1'b1;
			wait_cycles(HALF_CYCLES);
			pins_out.sclk <= 1'b0;
		end
		wait_cycles(HALF_CYCLES);
		pins_out.cs_n <= 1'b1;
		// Released line shows no stale bit
		pins_out.mosi <= ~pins_out.mosi;
		wait_cycles(HALF_CYCLES);
	endtask : xfer

endmodule : spi_host_model

// [test_irq_mask_and_shutdown_timing.sv]
// Self-checking bench for the fault mask, switch gap and shutdown timing bank.
// Assumes the host model for register access and a 10 MHz device clock.
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
	$display("Error at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module test_irq_mask_and_shutdown_timing;
	localparam int unsigned P = pm_regs_pkg::CLK_PERIOD_NS;

	logic                    clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic [7:0]              fault_src = 8'h00;
	logic                    led_req = 1'b0;
	logic                    fsd_start = 1'b0;
	pm_regs_pkg::spi_pins_s  pins;
	logic                    miso, miso_oe, irq_n, gap_active, go, ofs_step, bias_step, sd_busy;
	int                      fail_count = 0;
	int                      n_tests = 0;

	always #50 clk = ~clk;

	spi_host_model host (.sys_clk_in(clk), .miso_in(miso), .miso_oe_in(miso_oe), .pins_out(pins));

	irq_mask_and_shutdown_timing #(.CLK_PERIOD_NS(P)) dut (
		.sys_clk_in(clk), .rst_n_in(rst_n), .sclk_in(pins.sclk), .cs_n_in(pins.cs_n),
		.mosi_in(pins.mosi), .miso_out(miso), .miso_oe_out(miso_oe), .fault_src_in(fault_src),
		.irq_n_out(irq_n), .led_switch_req_in(led_req), .switch_gap_active_out(gap_active),
		.switch_go_out(go), .fast_shutdown_in(fsd_start), .offset_reset_step_out(ofs_step),
		.bias_reset_rail_step_out(bias_step), .shutdown_busy_out(sd_busy));

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
		logic [7:0] rd;
		host.xfer({1'b1, addr, data}, rd);
	endtask : write_reg

	task automatic check_reg(input logic [6:0] addr, input logic [7:0] exp);
		logic [7:0] rd;
		host.xfer({1'b0, addr, 8'h00}, rd);
		`CHECK(rd, exp)
	endtask : check_reg

	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset_values;
		check_reg(pm_regs_pkg::GAP_ADDR, 8'h00);
		check_reg(pm_regs_pkg::FSD_ADDR, 8'h07);
		check_reg(pm_regs_pkg::OFS_DUR_ADDR, 8'hc0);
		check_reg(pm_regs_pkg::MASK_ADDR, 8'hf5);
		// Unmapped place takes no write and reads zero
		write_reg(7'h7f, 8'h5a);
		check_reg(7'h7f, 8'h00);
		$display("test reset_values done");
	endtask : test_reset_values

	task automatic test_masks;
		logic [7:0] bit_sel;
		for (int b = 0; b < 8; b++)
		begin
			bit_sel = 8'h01 << b;
			write_reg(pm_regs_pkg::MASK_ADDR, bit_sel);
			@(posedge clk) fault_src <= bit_sel;
			repeat (3) @(posedge clk);
			`CHECK(irq_n, 1'b1)
			check_reg(pm_regs_pkg::STATUS_ADDR, bit_sel);
			write_reg(pm_regs_pkg::MASK_ADDR, ~bit_sel);
			repeat (3) @(posedge clk);
			`CHECK(irq_n, 1'b0)
			write_reg(pm_regs_pkg::STATUS_ADDR, bit_sel);
			repeat (3) @(posedge clk);
			`CHECK(irq_n, 1'b1)
			@(posedge clk) fault_src <= 8'h00;
		end
		$display("test masks done");
	endtask : test_masks

	task automatic test_gap(input logic [7:0] code);
		int exp_cycles, busy_cnt, seen;
		exp_cycles = (code == 8'h00) ? 0 : (222 + 111 * code + P - 1) / P;
		busy_cnt = 0;
		seen = 0;
		write_reg(pm_regs_pkg::GAP_ADDR, code);
		@(posedge clk) led_req <= 1'b1;
		for (int k = 0; k < 400 && seen == 0; k++)
		begin
			@(posedge clk);
			led_req <= 1'b0;
			if (gap_active === 1'b1)
				busy_cnt++;
			if (go === 1'b1)
				seen = 1;
		end
		`CHECK(seen, 1)
		`CHECK(busy_cnt, exp_cycles)
		$display("test gap code %0h done", code);
	endtask : test_gap

	task automatic test_shutdown(input logic [7:0] code);
		int n1, n2, busy_cnt, t1, t2;
		n1 = (pm_regs_pkg::FSD_MIN_NS[code[7:4]] + P - 1) / P;
		n2 = (pm_regs_pkg::FSD_MIN_NS[code[3:0]] + P - 1) / P;
		busy_cnt = 0;
		t1 = -1;
		t2 = -1;
		write_reg(pm_regs_pkg::FSD_ADDR, code);
		@(posedge clk) fsd_start <= 1'b1;
		for (int k = 0; k < 20000 && t2 < 0; k++)
		begin
			@(posedge clk);
			// Second start while busy must not restart the sequence
			fsd_start <= (k == 20);
			// Busy cycles before the offset pulse make up the first delay
			if (ofs_step === 1'b1)
				t1 = k;
			if (sd_busy === 1'b1 && t1 < 0)
				busy_cnt++;
			if (bias_step === 1'b1)
				t2 = k;
		end
		`CHECK(busy_cnt, n1)
		`CHECK(t2 - t1, n2 + 1)
		$display("test shutdown code %0h done", code);
	endtask : test_shutdown

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		test_reset_values();
		test_masks();
		test_gap(8'h00);
		test_gap(8'h01);
		test_gap(8'hff);
		test_shutdown(8'h07);
		test_shutdown(8'hf8);
		finish_test();
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		$display("Error at %0t ns: watchdog expired %0h %0h", $time, n_tests, 0);
		finish_test();
	end

endmodule : test_irq_mask_and_shutdown_timing
